/* File: asc_cfg.svh */
// Constants of the asynchronous serial transmitter/receiver core.
// Assumes inclusion by bare name from the core module.
// How it works
// RL1 - Words of 8 or 9 bits, ninth from control
// RL2 - Start bit low, stop high, LSB first
// RL3 - Idle is 10 or 11 bit times high
// RL4 - Enabling transmitter sends 10/11 ones preamble
// RL5 - Empty flag set on buffer move, sequence clears
// RL6 - Write while busy waits in holding buffer
// RL7 - Write while idle starts at once, flags empty
// RL8 - Complete flag after stop bit or break
// RL9 - Breaks repeat while set, then one 1 bit
// RL10 - Retoggling enable sends preamble, drops pending data
// RL11 - Receiver enable hunts start, ninth bit stored
// RL12 - Received word moves to buffer, full flag set
// RL13 - Idle line raises flag and interrupt
// RL14 - Overrun keeps buffer, flags, interrupts
// RL15 - Error flags clear by status then data read
// RL16 - Noise flag rides with full flag
// RL17 - Missing stop bit or break sets framing
// RL18 - Break reads as framing error with 00h
// RL19 - Baud is clock over 16, PR, divisor
// RL20 - Nonzero fine prescaler divides further, zero bypasses
// RL21 - Software keeps baud setup still while enabled
// RL22 - Pin idles high when on, released when off
// RL23 - Sixteen-times sampling, mid-bit majority, noise check
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ASC_OFF_STATUS 8'h00
`define ASC_OFF_DATA   8'h04
`define ASC_OFF_CTRL1  8'h08
`define ASC_OFF_CTRL2  8'h0C
`define ASC_OFF_BAUD   8'h10
`define ASC_OFF_RXFINE 8'h14
`define ASC_OFF_TXFINE 8'h18
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ASC_C1_RX9     7
`define ASC_C1_TX9     6
`define ASC_C1_NINE    4
`define ASC_STATUS_RST 8'hC0
`define ASC_CTRL_RST   8'h00
// ----------------------------------------------------------------
// Framing, sampling and baud prescaler values
// ----------------------------------------------------------------
`define ASC_LEN8       4'hA
`define ASC_LEN9       4'hB
`define ASC_PHASE_LAST 4'hF
`define ASC_SMP_A      4'h7
`define ASC_SMP_C      4'h9
`define ASC_PR0        5'h01
`define ASC_PR1        5'h03
`define ASC_PR2        5'h04
`define ASC_PR3        5'h0D
`endif

/* File: asc_pkg.sv */
// Types shared by the serial core: status layout, controls, states.
// Assumes asc_cfg.svh is reachable on the include path.
package asc_pkg;
  typedef struct packed {
    logic txe;
    logic txc;
    logic rxf;
    logic idle;
    logic ovr;
    logic noise;
    logic frm;
    logic rsv;
  } asc_status_t;

  typedef struct packed {
    logic txe_ie;
    logic txc_ie;
    logic rxf_ie;
    logic idle_ie;
    logic tx_on;
    logic rx_on;
    logic rsv;
    logic brk;
  } asc_ctrl2_t;

  typedef struct packed {
    logic [1:0] pre;
    logic [2:0] tr;
    logic [2:0] rr;
  } asc_baud_t;

  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_DATA, TX_BRK, TX_TAIL} asc_tx_state_t;
  typedef enum logic {RX_HUNT, RX_BITS} asc_rx_state_t;
endpackage : asc_pkg

/* File: asc_core.sv */
// Asynchronous serial transmitter/receiver with a classic Wishbone slave.
// Assumes one clock, synchronous active-low reset and inputs already
// synchronous to the clock.
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "asc_cfg.svh"

// ----------------------------------------------------------------
// Sixteen-times baud tick from a cycle divisor
// ----------------------------------------------------------------
module asc_tick #(
  parameter int DW = 20
) (
  // System
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic          ce,
  // Control
  input  wire logic          run,
  input  wire logic [DW-1:0] div,
  // Tick
  output logic               tick
);
  logic [DW-1:0] cnt_q;
  logic          wrap;

  assign wrap = cnt_q >= div - DW'(1);
  assign tick = ce & run & wrap;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (!run || wrap) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + DW'(1);
      end
    end
  end
endmodule : asc_tick

// ----------------------------------------------------------------
// Core
// ----------------------------------------------------------------
module asc_core #(
  parameter int ADDR_W = 8
) (
  // System
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Serial pins
  input  wire logic              serial_in_pin,
  output logic                   serial_out_pin,
  output logic                   serial_out_oe,
  // Interrupt request
  output logic                   irq
);
  import asc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  asc_status_t   status_q;
  asc_ctrl2_t    ctrl2_q;
  asc_baud_t     baud_q;
  asc_tx_state_t tx_state_q;
  asc_rx_state_t rx_state_q;
  logic          nine_q;
  logic          tx9_q;
  logic          rx9_q;
  logic [7:0]    rx_fine_q;
  logic [7:0]    tx_fine_q;
  logic          ack_q;
  logic [31:0]   dat_q;
  logic          seen_q;
  logic          irq_q;
  logic [7:0]    hold_q;
  logic          hold_valid_q;
  logic          tx_on_prev_q;
  logic          pre_pend_q;
  logic [10:0]   tx_shift_q;
  logic [3:0]    tx_bits_q;
  logic [3:0]    tx_phase_q;
  logic          out_q;
  logic          oe_q;
  logic [3:0]    rx_phase_q;
  logic [3:0]    rx_idx_q;
  logic [2:0]    rx_smp_q;
  logic [8:0]    rx_shift_q;
  logic          rx_noisy_q;
  logic [7:0]    rx_buf_q;
  logic [7:0]    idle_cnt_q;
  logic          idle_armed_q;

  logic          access;
  logic          wr;
  logic          rd;
  logic          clr_tx;
  logic          clr_rx;
  logic [3:0]    len;
  logic [7:0]    idle_ticks;
  logic [19:0]   tx_div;
  logic [19:0]   rx_div;
  logic          tx_tick;
  logic          rx_tick;
  logic          tx_run;
  logic          tx_bit_end;
  logic          tx_load;
  logic          tx_done_ev;
  logic          rx_bit_end;
  logic          rx_maj;
  logic          rx_noise_bit;
  logic          rx_done;
  logic          idle_ev;

  // ----------------------------------------------------------------
  // Baud divisors
  // ----------------------------------------------------------------
  function automatic logic [19:0] asc_div(input logic [1:0] pre, input logic [2:0] sel,
                                          input logic [7:0] fine);
    logic [27:0] p;
    logic [4:0]  pr;
    unique case (pre)
      2'h0: pr = `ASC_PR0;
      2'h1: pr = `ASC_PR1;
      2'h2: pr = `ASC_PR2;
      2'h3: pr = `ASC_PR3;
    endcase
    p = {23'h000000, pr} << sel;
    // Zero keeps the fine prescaler out of the path
    if (fine != 8'h00) begin
      p = 28'(p * {20'h00000, fine}); // RL20
    end
    return p[19:0];
  endfunction : asc_div

  assign tx_div = asc_div(baud_q.pre, baud_q.tr, tx_fine_q); // RL19
  assign rx_div = asc_div(baud_q.pre, baud_q.rr, rx_fine_q); // RL19
  // Divisors are read live; changing them mid-frame skews the bit in flight
  assign tx_run = ctrl2_q.tx_on | (tx_state_q != TX_IDLE); // RL21

  asc_tick #(.DW(20)) u_tx_tick (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .run   (tx_run),
    .div   (tx_div),
    .tick  (tx_tick)
  );

  asc_tick #(.DW(20)) u_rx_tick (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .run   (ctrl2_q.rx_on),
    .div   (rx_div),
    .tick  (rx_tick)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign access = ce & wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr     = access & wb_we_i & wb_sel_i[0];
  assign rd     = access & ~wb_we_i;
  assign clr_tx = wr & (wb_adr_i[7:0] == `ASC_OFF_DATA) & seen_q; // RL5
  assign clr_rx = rd & (wb_adr_i[7:0] == `ASC_OFF_DATA) & seen_q; // RL15
  assign len        = nine_q ? `ASC_LEN9 : `ASC_LEN8; // RL1
  assign idle_ticks = {len, 4'h0};

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      dat_q <= 32'h00000000;
    end else if (rd) begin
      unique case (wb_adr_i[7:0])
        `ASC_OFF_STATUS: dat_q <= {24'h000000, status_q};
        `ASC_OFF_DATA:   dat_q <= {24'h000000, rx_buf_q};
        `ASC_OFF_CTRL1:  dat_q <= {24'h000000, rx9_q, tx9_q, 1'b0, nine_q, 4'h0};
        `ASC_OFF_CTRL2:  dat_q <= {24'h000000, ctrl2_q};
        `ASC_OFF_BAUD:   dat_q <= {24'h000000, baud_q};
        `ASC_OFF_RXFINE: dat_q <= {24'h000000, rx_fine_q};
        `ASC_OFF_TXFINE: dat_q <= {24'h000000, tx_fine_q};
        default:         dat_q <= 32'h00000000;
      endcase
    end
  end

  // Status access arms the clear; the next data access consumes it
  always_ff @(posedge clock) begin
    if (!nrst) begin
      seen_q <= 1'b0;
    end else if (access) begin
      if (wb_adr_i[7:0] == `ASC_OFF_STATUS) begin
        seen_q <= 1'b1;
      end else if (wb_adr_i[7:0] == `ASC_OFF_DATA) begin
        seen_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      nine_q    <= 1'b0;
      tx9_q     <= 1'b0;
      ctrl2_q   <= `ASC_CTRL_RST;
      baud_q    <= `ASC_CTRL_RST;
      rx_fine_q <= `ASC_CTRL_RST;
      tx_fine_q <= `ASC_CTRL_RST;
    end else if (wr) begin
      unique case (wb_adr_i[7:0])
        `ASC_OFF_CTRL1: begin
          nine_q <= wb_dat_i[`ASC_C1_NINE];
          tx9_q  <= wb_dat_i[`ASC_C1_TX9];
        end
        `ASC_OFF_CTRL2:  ctrl2_q   <= wb_dat_i[7:0];
        `ASC_OFF_BAUD:   baud_q    <= wb_dat_i[7:0];
        `ASC_OFF_RXFINE: rx_fine_q <= wb_dat_i[7:0];
        `ASC_OFF_TXFINE: tx_fine_q <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit holding buffer and preamble request
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      hold_q       <= 8'h00;
      hold_valid_q <= 1'b0;
    end else if (ce) begin
      if (!ctrl2_q.tx_on) begin
        hold_valid_q <= 1'b0; // RL10
      end else if (wr && wb_adr_i[7:0] == `ASC_OFF_DATA) begin
        hold_q       <= wb_dat_i[7:0]; // RL6
        hold_valid_q <= 1'b1;
      end else if (tx_load) begin
        hold_valid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      tx_on_prev_q <= 1'b0;
      pre_pend_q   <= 1'b0;
    end else if (ce) begin
      tx_on_prev_q <= ctrl2_q.tx_on;
      if (ctrl2_q.tx_on && !tx_on_prev_q) begin
        pre_pend_q <= 1'b1; // RL4 RL10
      end else if (tx_state_q == TX_IDLE && ctrl2_q.tx_on) begin
        pre_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  assign tx_bit_end = tx_tick & (tx_phase_q == `ASC_PHASE_LAST) & (tx_state_q != TX_IDLE);
  assign tx_load    = ce & (tx_state_q == TX_IDLE) & ctrl2_q.tx_on & ~pre_pend_q
                      & ~ctrl2_q.brk & hold_valid_q;
  assign tx_done_ev = tx_bit_end & (tx_bits_q == 4'h1)
                      & ((tx_state_q == TX_DATA) | (tx_state_q == TX_BRK)); // RL8

  always_ff @(posedge clock) begin
    if (!nrst) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 11'h7FF;
      tx_bits_q  <= 4'h0;
      tx_phase_q <= 4'h0;
    end else if (ce) begin
      unique case (tx_state_q)
        TX_IDLE: begin
          tx_phase_q <= 4'h0;
          tx_bits_q  <= len; // RL3
          if (ctrl2_q.tx_on) begin
            if (pre_pend_q) begin
              tx_state_q <= TX_PRE; // RL4
              tx_shift_q <= 11'h7FF;
            end else if (ctrl2_q.brk) begin
              tx_state_q <= TX_BRK; // RL9
              tx_shift_q <= 11'h000;
            end else if (hold_valid_q) begin
              tx_state_q <= TX_DATA; // RL7
              tx_shift_q <= nine_q ? {1'b1, tx9_q, hold_q, 1'b0}
                                   : {2'b11, hold_q, 1'b0}; // RL1 RL2
            end
          end
        end
        TX_PRE, TX_DATA, TX_BRK, TX_TAIL: begin
          if (tx_tick) begin
            tx_phase_q <= tx_phase_q + 4'h1;
          end
          if (tx_bit_end) begin
            tx_shift_q <= {1'b1, tx_shift_q[10:1]}; // RL2
            tx_bits_q  <= tx_bits_q - 4'h1;
            if (tx_bits_q == 4'h1) begin
              if (tx_state_q == TX_BRK && ctrl2_q.brk) begin
                tx_shift_q <= 11'h000; // RL9
                tx_bits_q  <= len;
              end else if (tx_state_q == TX_BRK) begin
                tx_state_q <= TX_TAIL; // RL9
                tx_shift_q <= 11'h7FF;
                tx_bits_q  <= 4'h1;
              end else begin
                tx_state_q <= TX_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      out_q <= 1'b1;
      oe_q  <= 1'b0;
    end else if (ce) begin
      out_q <= (tx_state_q == TX_IDLE) ? 1'b1 : tx_shift_q[0]; // RL22
      oe_q  <= tx_run; // RL22
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  assign rx_bit_end   = rx_tick & (rx_state_q == RX_BITS) & (rx_phase_q == `ASC_PHASE_LAST);
  assign rx_maj       = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] & rx_smp_q[2])
                        | (rx_smp_q[1] & rx_smp_q[2]); // RL23
  assign rx_noise_bit = (|rx_smp_q) & ~(&rx_smp_q); // RL23
  assign rx_done      = rx_bit_end & (rx_idx_q == len - 4'h1);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rx_state_q <= RX_HUNT;
      rx_phase_q <= 4'h0;
      rx_idx_q   <= 4'h0;
      rx_smp_q   <= 3'h0;
      rx_shift_q <= 9'h000;
      rx_noisy_q <= 1'b0;
    end else if (ce) begin
      if (!ctrl2_q.rx_on) begin
        rx_state_q <= RX_HUNT;
      end else if (rx_tick) begin
        unique case (rx_state_q)
          RX_HUNT: begin
            if (!serial_in_pin) begin
              rx_state_q <= RX_BITS; // RL11
              rx_phase_q <= 4'h1;
              rx_idx_q   <= 4'h0;
              rx_noisy_q <= 1'b0;
            end
          end
          RX_BITS: begin
            rx_phase_q <= rx_phase_q + 4'h1;
            if (rx_phase_q >= `ASC_SMP_A && rx_phase_q <= `ASC_SMP_C) begin
              rx_smp_q <= {rx_smp_q[1:0], serial_in_pin}; // RL23
            end
            if (rx_phase_q == `ASC_PHASE_LAST) begin
              rx_noisy_q <= rx_noisy_q | rx_noise_bit;
              // A start bit that fails the vote was a glitch
              if ((rx_idx_q == 4'h0 && rx_maj) || rx_done) begin
                rx_state_q <= RX_HUNT;
              end else begin
                if (rx_idx_q != 4'h0) begin
                  rx_shift_q[4'(rx_idx_q - 4'h1)] <= rx_maj; // RL11
                end
                rx_idx_q <= rx_idx_q + 4'h1;
              end
            end
          end
        endcase
      end
    end
  end

  // Idle line: a full character time of high after a received word
  assign idle_ev = rx_tick & (rx_state_q == RX_HUNT) & serial_in_pin & idle_armed_q
                   & (idle_cnt_q == idle_ticks - 8'h01); // RL3 RL13

  always_ff @(posedge clock) begin
    if (!nrst) begin
      idle_cnt_q   <= 8'h00;
      idle_armed_q <= 1'b0;
    end else if (ce) begin
      if (!ctrl2_q.rx_on) begin
        idle_cnt_q   <= 8'h00;
        idle_armed_q <= 1'b0;
      end else if (rx_done) begin
        idle_cnt_q   <= 8'h00;
        idle_armed_q <= 1'b1;
      end else if (idle_ev) begin
        idle_armed_q <= 1'b0;
      end else if (rx_tick && rx_state_q == RX_HUNT) begin
        idle_cnt_q <= serial_in_pin ? idle_cnt_q + 8'h01 : 8'h00;
      end
    end
  end

  // Overrun leaves the buffer alone so the unread word survives
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rx_buf_q <= 8'h00;
      rx9_q    <= 1'b0;
    end else if (rx_done && !status_q.rxf) begin
      rx_buf_q <= rx_shift_q[7:0]; // RL12 RL18
      rx9_q    <= nine_q & rx_shift_q[8]; // RL11
    end
  end

  // ----------------------------------------------------------------
  // Status flags: a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      status_q <= `ASC_STATUS_RST;
    end else if (ce) begin
      status_q.txe   <= tx_load | (status_q.txe & ~clr_tx); // RL5 RL7
      status_q.txc   <= tx_done_ev | (status_q.txc & ~clr_tx); // RL8
      status_q.rxf   <= rx_done | (status_q.rxf & ~clr_rx); // RL12
      status_q.idle  <= idle_ev | (status_q.idle & ~clr_rx); // RL13
      status_q.ovr   <= (rx_done & status_q.rxf) | (status_q.ovr & ~clr_rx); // RL14 RL15
      status_q.noise <= (rx_done & ~status_q.rxf & (rx_noisy_q | rx_noise_bit))
                        | (status_q.noise & ~clr_rx); // RL16 RL15
      status_q.frm   <= (rx_done & ~status_q.rxf & ~rx_maj)
                        | (status_q.frm & ~clr_rx); // RL17 RL18 RL15
      status_q.rsv   <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= (status_q.txe & ctrl2_q.txe_ie) | (status_q.txc & ctrl2_q.txc_ie)
               | ((status_q.rxf | status_q.ovr) & ctrl2_q.rxf_ie)
               | (status_q.idle & ctrl2_q.idle_ie); // RL5 RL8 RL12 RL13 RL14
    end
  end

  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = dat_q;
  assign serial_out_pin = out_q;
  assign serial_out_oe  = oe_q;
  assign irq            = irq_q;
endmodule : asc_core

/* File: asc_core_asserts.sv */
// Checker for the serial core, watching only the top-level ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module asc_core_asserts #(
  parameter int ADDR_W = 8
) (
  // System
  input wire logic              clock,
  input wire logic              nrst,
  input wire logic              ce,
  // Wishbone
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  // Serial and interrupt
  input wire logic              serial_in_pin,
  input wire logic              serial_out_pin,
  input wire logic              serial_out_oe,
  input wire logic              irq
);
  logic [7:0] c2_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // Shadow of control_two, in step with the core's copy
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst)
      c2_q <= 8'h00;
    else if (ce && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h0C
             && wb_sel_i[0])
      c2_q <= wb_dat_i[7:0];
  end
  property p_ack_one;
    (wb_cyc_i && wb_stb_i && !wb_ack_o && ce) |=> wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_unmapped;
    (wb_ack_o && !wb_we_i && wb_adr_i == 8'h20) |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_stat_rsv;
    (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00) |-> (wb_dat_o[31:8] == 24'h0 && !wb_dat_o[0]);
  endproperty
  a_stat_rsv: assert property (p_stat_rsv) else $error("status spare bits set");
  property p_start_low;
    $fell(serial_out_pin) |-> !serial_out_pin [*8];
  endproperty
  a_start_low: assert property (p_start_low) else $error("low bit too short");
  property p_preamble;
    $rose(c2_q[3]) |-> serial_out_pin [*8];
  endproperty
  a_preamble: assert property (p_preamble) else $error("no idle preamble");
  property p_oe_on;
    c2_q[3] |=> serial_out_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin not owned");
  property p_irq_quiet;
    (c2_q[7:4] == 4'h0 && $past(c2_q[7:4]) == 4'h0) |-> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq while masked");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_start: cover property ($fell(serial_out_pin));
endmodule : asc_core_asserts

bind asc_core asc_core_asserts #(.ADDR_W(ADDR_W)) i_chk (.clock(clock), .nrst(nrst), .ce(ce),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .serial_out_oe(serial_out_oe), .irq(irq));

/* File: asc_remote.sv */
// Remote serial node: sends frames on demand and decodes the core's line.
// Assumes the bench sets bit length in clock cycles and the word length.
`timescale 1ns/1ns
module asc_remote (
  // System
  input  wire logic        clock,
  // Format
  input  wire logic [15:0] bit_cyc,
  input  wire logic        nine,
  // Serial pins
  input  wire logic        serial_out_pin,
  input  wire logic        serial_out_oe,
  output logic             serial_in_pin
);
  logic       line;
  logic [9:0] rx_q[$];
  realtime    t_first;
  // Released pin reads as the pulled-up idle level
  assign line = serial_out_oe ? serial_out_pin : 1'b1;
  initial serial_in_pin = 1'b1;
  task automatic send(input logic [8:0] d, input logic stp);
    for (int k = 0; k < (nine ? 11 : 10); k++) begin
      @(posedge clock);
      serial_in_pin <= (k == 0) ? 1'b0 : ((k == (nine ? 10 : 9)) ? stp : d[k-1]);
      repeat (bit_cyc - 1) @(posedge clock);
    end
    @(posedge clock);
    serial_in_pin <= 1'b1;
  endtask : send
  // Stored as {stop, data}; a long low stretch counts as one frame
  always begin : rx_loop
    logic [9:0] f;
    @(posedge clock);
    if (line === 1'b0) begin
      if (rx_q.size() == 0) t_first = $realtime;
      f = 10'h000;
      repeat (bit_cyc / 2) @(posedge clock);
      for (int i = 0; i < (nine ? 10 : 9); i++) begin
        repeat (bit_cyc) @(posedge clock);
        f[(i == (nine ? 9 : 8)) ? 9 : i] = line;
      end
      rx_q.push_back(f);
      while (line !== 1'b1) @(posedge clock);
    end
  end
endmodule : asc_remote

/* File: asc_core_tb.sv */
// Self-checking bench for the serial core over classic Wishbone.
// Assumes the core, checker and remote node are compiled before it.
`timescale 1ns/1ns
module asc_core_tb;
  import asc_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dwr = 32'h0;
  logic [31:0] drd;
  logic [31:0] v;
  logic        ack, sin, sout, soe, irq;
  logic [15:0] bit_cyc = 16'h0010;
  logic        nine = 1'b0;
  logic [9:0]  fr;
  realtime     t0;
  int          err_total = 0;
  int          cmp_count = 0;
  always #10 clock = ~clock;
  asc_core i_dut (.clock(clock), .nrst(nrst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(4'h1), .wb_adr_i(adr), .wb_dat_i(dwr), .wb_dat_o(drd),
    .wb_ack_o(ack), .serial_in_pin(sin), .serial_out_pin(sout), .serial_out_oe(soe),
    .irq(irq));
  asc_remote i_rem (.clock(clock), .bit_cyc(bit_cyc), .nine(nine), .serial_out_pin(sout),
    .serial_out_oe(soe), .serial_in_pin(sin));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Request held until ack is sampled, then released for one cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dwr <= {24'h0, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    v = drd;
    chk("ack", {31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, v & {24'h0, m}, {24'h0, e});
  endtask : rdc
  task automatic rx_chk(input logic [9:0] e);
    for (int i = 0; i < 6000 && i_rem.rx_q.size() == 0; i++) @(posedge clock);
    fr = (i_rem.rx_q.size() > 0) ? i_rem.rx_q.pop_front() : 10'hXXX;
    chk("frame", {22'h0, fr}, {22'h0, e});
  endtask : rx_chk
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  initial begin : watchdog
    #1500000;
    err_total++;
    $display("unexpected watchdog: expected end seen hang");
    end_sim();
  end
  initial begin : main
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rdc("status", 8'h00, 8'hFF, 8'hC0);
    rdc("unmapped", 8'h20, 8'hFF, 8'h00);
    bus(1'b1, 8'h0C, 8'h24);
    rdc("control_two", 8'h0C, 8'hFF, 8'h24);
    $display("test registers done");
    i_rem.send(9'h05A, 1'b1);
    repeat (4) @(posedge clock);
    chk("irq", {31'h0, irq}, 32'h1);
    rdc("status", 8'h00, 8'h2E, 8'h20);
    rdc("data", 8'h04, 8'hFF, 8'h5A);
    repeat (3) @(posedge clock);
    chk("irq", {31'h0, irq}, 32'h0);
    repeat (180) @(posedge clock);
    rdc("status", 8'h00, 8'h30, 8'h10);
    bus(1'b0, 8'h04, 8'h00);
    i_rem.send(9'h011, 1'b1);
    i_rem.send(9'h022, 1'b1);
    repeat (4) @(posedge clock);
    rdc("status", 8'h00, 8'h28, 8'h28);
    rdc("data", 8'h04, 8'hFF, 8'h11);
    rdc("status", 8'h00, 8'h2E, 8'h00);
    i_rem.send(9'h000, 1'b0);
    repeat (4) @(posedge clock);
    rdc("status", 8'h00, 8'h22, 8'h22);
    rdc("data", 8'h04, 8'hFF, 8'h00);
    $display("test receive done");
    i_rem.rx_q.delete();
    t0 = $realtime;
    bus(1'b1, 8'h0C, 8'h0C);
    bus(1'b0, 8'h00, 8'h00);
    bus(1'b1, 8'h04, 8'hA5);
    rx_chk(10'h2A5);
    chk("preamble", {31'h0, logic'(i_rem.t_first - t0 >= 3200.0)}, 32'h1);
    repeat (20) @(posedge clock);
    rdc("status", 8'h00, 8'hC0, 8'hC0);
    bus(1'b1, 8'h04, 8'h3C);
    rdc("status", 8'h00, 8'hC0, 8'h80);
    bus(1'b1, 8'h04, 8'h69);
    rdc("status", 8'h00, 8'h80, 8'h00);
    rx_chk(10'h23C);
    rx_chk(10'h269);
    bus(1'b1, 8'h0C, 8'h0D);
    rx_chk(10'h000);
    bus(1'b1, 8'h0C, 8'h0C);
    repeat (200) @(posedge clock);
    $display("test transmit done");
    nine <= 1'b1;
    bus(1'b1, 8'h08, 8'h50);
    bus(1'b0, 8'h00, 8'h00);
    bus(1'b1, 8'h04, 8'h81);
    rx_chk(10'h381);
    i_rem.send(9'h1C3, 1'b1);
    repeat (4) @(posedge clock);
    rdc("control_one", 8'h08, 8'h80, 8'h80);
    rdc("data", 8'h04, 8'hFF, 8'hC3);
    nine <= 1'b0;
    bus(1'b1, 8'h08, 8'h00);
    bus(1'b1, 8'h0C, 8'h00);
    bus(1'b1, 8'h10, 8'h08);
    bit_cyc <= 16'h0020;
    bus(1'b1, 8'h0C, 8'h08);
    bus(1'b0, 8'h00, 8'h00);
    bus(1'b1, 8'h04, 8'h96);
    rx_chk(10'h296);
    $display("test format and rate done");
    end_sim();
  end
endmodule : asc_core_tb
